// ---- common/clock_monitor_pkg.sv ----
// constants and types shared by the clock lock and loss monitor
package clock_monitor_pkg;
  localparam int CLOCK_HZ = 20_000_000;
  localparam int CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;
  // loss detection latency, rounded down to whole cycles
  localparam int LOSS_TIME_NS = 10_000;
  localparam int LOSS_CYCLES = LOSS_TIME_NS / CLOCK_PERIOD_NS;
  // power-up window in which clock edges on the pin are looked for
  localparam int DETECT_TIME_NS = 10_000;
  localparam int DETECT_CYCLES = DETECT_TIME_NS / CLOCK_PERIOD_NS;
  // supported free-running range, as switching periods in cycles
  localparam int MIN_SWITCH_HZ = 200_000;
  localparam int MAX_SWITCH_HZ = 1_000_000;
  localparam int MAX_PERIOD = CLOCK_HZ / MIN_SWITCH_HZ;
  localparam int MIN_PERIOD = CLOCK_HZ / MAX_SWITCH_HZ;
  // lock window of plus or minus 20 percent, as ratios over five
  localparam int LOCK_LOW_NUM = 4;
  localparam int LOCK_HIGH_NUM = 6;
  localparam int LOCK_DEN = 5;
  // 40 percent lower frequency means a period of five thirds
  localparam int SLOW_NUM = 5;
  localparam int SLOW_DEN = 3;
  localparam logic [2:0] RESTORE_EDGES = 3'h7;
  // register offsets on the command port
  localparam logic [7:0] STATUS_OFFSET = 8'h80;
  localparam logic [7:0] MISC_OFFSET = 8'hF0;
  localparam logic [7:0] MISC_RESET = 8'h00;
  // misc configuration fields
  localparam int FAULT_DISABLE_BIT = 0;
  localparam int FORCE_FOLLOW_BIT = 1;
  localparam int FORCE_DRIVE_BIT = 2;
  // manufacturer status fields
  localparam int STATUS_LOSS_BIT = 5;
  localparam int STATUS_FOLLOW_BIT = 6;
  localparam int STATUS_RUN_BIT = 7;

  typedef enum logic [2:0] {
    DETECT = 3'h0,
    DRIVE_RUN = 3'h1,
    FOLLOW_WAIT = 3'h2,
    FOLLOW_RESTORE = 3'h3,
    FOLLOW_RUN = 3'h4,
    FOLLOW_FREE = 3'h5
  } state_type;
endpackage

// ---- rtl/pin_synchroniser.sv ----
// two flip-flop synchroniser for pin level inputs
`timescale 1ns/1ps
module pin_synchroniser #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] firstStage;

  // first stage feeds only the second stage
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      firstStage <= '0;
      pinSync <= '0;
    end else begin
      firstStage <= pinIn;
      pinSync <= firstStage;
    end
  end
endmodule

// ---- rtl/switch_phase_counter.sv ----
// switching period counter with restart and half-period marker
`timescale 1ns/1ps
module switch_phase_counter (
  input wire logic clock,
  input wire logic reset,
  input wire logic restart,
  input wire logic [7:0] limit,
  output logic phaseStart,
  output logic firstHalf
);
  logic [7:0] count;
  logic [7:0] next_count;

  // wrap at the limit, or jump to zero on a locking edge
  always_comb begin
    if (restart || count >= limit - 8'h01) begin
      next_count = 8'h00;
    end else begin
      next_count = count + 8'h01;
    end
  end

  // phase start pulse and an even high/low split of the period
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= 8'h00;
      phaseStart <= 1'b0;
      firstHalf <= 1'b0;
    end else begin
      count <= next_count;
      phaseStart <= (next_count == 8'h00);
      firstHalf <= (next_count < {1'b0, limit[7:1]});
    end
  end
endmodule

// ---- rtl/switching_clock_monitor.sv ----
// Contract
// - detected clock at start-up: follow rising edge
// - no clock at start-up: drive own clock out
// - driving master outputs 50% duty clock
// - loop slave always follows, falling edge
// - lock to clocks within 20% of free-run
// - free-running range 200 kHz to 1 MHz
// - auto-chosen pin mode fixed until power cycle
// - force bits override; force-follow beats force-drive
// - force bits cleared after power-up
// - lost clock stops switching, live status flag
// - clock-loss flag never raises bus alert
// - loss found in 10 us; slave runs slow
// - never-present clock keeps switching off
// - seven edges after return, then soft-start
// - fault disable: no flag, no stop, free-run
`timescale 1ns/1ps
module switching_clock_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockPinIn,
  input wire logic loopSlaveStrap,
  input wire logic [6:0] periodStrap,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  output logic clockPinOut,
  output logic clockPinOe,
  output logic switchPulse,
  output logic softStartPulse,
  output logic followMode,
  output logic busAlert
);
  localparam int LOSS_CYC = clock_monitor_pkg::LOSS_CYCLES;
  // count held by the restore counter when the last needed edge arrives
  localparam logic [2:0] RESTORE_LAST = clock_monitor_pkg::RESTORE_EDGES -
    3'h1;

  clock_monitor_pkg::state_type state;
  logic [8:0] pinSync;
  logic pinLast;
  logic [7:0] misc;
  logic [7:0] freePeriod;
  logic slaveRole;
  logic [7:0] detectCount;
  logic [1:0] detectEdges;
  logic [7:0] gap;
  logic [2:0] restoreCount;
  logic lossFlag;
  logic phaseStart;
  logic firstHalf;
  logic rise;
  logic fall;
  logic lockEdge;
  logic validEdge;
  logic lossSeen;
  logic faultDisable;
  logic detectDone;
  logic next_follow;
  logic [10:0] gapScaled;
  logic [10:0] lowBound;
  logic [10:0] highBound;
  logic [7:0] clampedPeriod;
  logic [7:0] slowPeriod;
  logic [7:0] phaseLimit;
  logic phaseRestart;
  logic switchEnable;

  // pin clock and straps cross in through two flops
  pin_synchroniser #(.WIDTH(9)) pinSyncer (
    .clock(clock),
    .reset(reset),
    .pinIn({loopSlaveStrap, periodStrap, clockPinIn}),
    .pinSync(pinSync)
  );

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pinLast <= 1'b0;
    end else begin
      pinLast <= pinSync[0];
    end
  end

  assign rise = pinSync[0] & ~pinLast;
  assign fall = ~pinSync[0] & pinLast;
  assign faultDisable = misc[clock_monitor_pkg::FAULT_DISABLE_BIT];
  assign detectDone = (state == clock_monitor_pkg::DETECT) &&
    (detectCount == 8'(clock_monitor_pkg::DETECT_CYCLES - 1));

  // slave locks on the falling edge, master on the rising one
  assign lockEdge = slaveRole ? fall : rise;

  // edge accepted only if its period lies in the lock window
  assign gapScaled = 11'(gap) * 11'(clock_monitor_pkg::LOCK_DEN);
  assign lowBound = 11'(freePeriod) * 11'(clock_monitor_pkg::LOCK_LOW_NUM);
  assign highBound = 11'(freePeriod) *
    11'(clock_monitor_pkg::LOCK_HIGH_NUM);
  assign validEdge = lockEdge && gapScaled >= lowBound &&
    gapScaled <= highBound;
  assign lossSeen = (gap >= 8'(LOSS_CYC));

  // strap clamped into the supported frequency range
  always_comb begin
    if (7'(clock_monitor_pkg::MIN_PERIOD) > pinSync[7:1]) begin
      clampedPeriod = 8'(clock_monitor_pkg::MIN_PERIOD);
    end else if (pinSync[7:1] > 7'(clock_monitor_pkg::MAX_PERIOD)) begin
      clampedPeriod = 8'(clock_monitor_pkg::MAX_PERIOD);
    end else begin
      clampedPeriod = {1'b0, pinSync[7:1]};
    end
  end

  // loop-slave strap first, then force-follow, then force-drive, then detection result
  always_comb begin
    if (slaveRole || pinSync[8]) begin
      next_follow = 1'b1;
    end else if (misc[clock_monitor_pkg::FORCE_FOLLOW_BIT]) begin
      next_follow = 1'b1;
    end else if (misc[clock_monitor_pkg::FORCE_DRIVE_BIT]) begin
      next_follow = 1'b0;
    end else begin
      next_follow = (detectEdges == 2'h2);
    end
  end

  // start-up watch of the pin; straps caught after reset release
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      detectCount <= 8'h00;
      detectEdges <= 2'h0;
      freePeriod <= 8'(clock_monitor_pkg::MAX_PERIOD);
      slaveRole <= 1'b0;
    end else if (state == clock_monitor_pkg::DETECT) begin
      detectCount <= detectCount + 8'h01;
      if (rise && detectEdges != 2'h2) begin
        detectEdges <= detectEdges + 2'h1;
      end
      if (detectDone) begin
        freePeriod <= clampedPeriod;
        slaveRole <= pinSync[8];
      end
    end
  end

  // cycles since the last locking edge, saturating
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gap <= 8'h00;
    end else if (lockEdge) begin
      gap <= 8'h00;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end

  // mode decided once; only a power cycle reopens detection
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= clock_monitor_pkg::DETECT;
      followMode <= 1'b0;
      restoreCount <= 3'h0;
      softStartPulse <= 1'b0;
    end else begin
      softStartPulse <= 1'b0;
      case (state)
        clock_monitor_pkg::DETECT: begin
          if (detectDone) begin
            followMode <= next_follow;
            state <= next_follow ? clock_monitor_pkg::FOLLOW_WAIT :
              clock_monitor_pkg::DRIVE_RUN;
          end
        end
        clock_monitor_pkg::DRIVE_RUN: begin
          state <= clock_monitor_pkg::DRIVE_RUN;
        end
        clock_monitor_pkg::FOLLOW_WAIT: begin
          restoreCount <= 3'h0;
          if (faultDisable) begin
            state <= clock_monitor_pkg::FOLLOW_FREE;
          end else if (validEdge) begin
            restoreCount <= 3'h1;
            state <= clock_monitor_pkg::FOLLOW_RESTORE;
          end
        end
        clock_monitor_pkg::FOLLOW_RESTORE: begin
          if (lossSeen) begin
            state <= clock_monitor_pkg::FOLLOW_WAIT;
          end else if (validEdge) begin
            restoreCount <= restoreCount + 3'h1;
            if (restoreCount == RESTORE_LAST) begin
              state <= clock_monitor_pkg::FOLLOW_RUN;
              softStartPulse <= 1'b1;
            end
          end
        end
        clock_monitor_pkg::FOLLOW_RUN: begin
          if (lossSeen) begin
            state <= faultDisable ? clock_monitor_pkg::FOLLOW_FREE :
              clock_monitor_pkg::FOLLOW_WAIT;
          end
        end
        clock_monitor_pkg::FOLLOW_FREE: begin
          if (validEdge) begin
            state <= clock_monitor_pkg::FOLLOW_RUN;
          end else if (!faultDisable) begin
            state <= clock_monitor_pkg::FOLLOW_WAIT;
          end
        end
        default: begin
          state <= clock_monitor_pkg::DETECT;
        end
      endcase
    end
  end

  // while the clock is missing but not yet declared lost, run slow
  assign slowPeriod = 8'((11'(freePeriod) * 11'(clock_monitor_pkg::SLOW_NUM))
    / 11'(clock_monitor_pkg::SLOW_DEN));
  assign phaseLimit = (state == clock_monitor_pkg::FOLLOW_RUN &&
    gap > freePeriod) ? slowPeriod : freePeriod;
  assign phaseRestart = validEdge &&
    state == clock_monitor_pkg::FOLLOW_RUN;
  assign switchEnable = (state == clock_monitor_pkg::DRIVE_RUN) ||
    (state == clock_monitor_pkg::FOLLOW_RUN) ||
    (state == clock_monitor_pkg::FOLLOW_FREE);

  switch_phase_counter phaseCounter (
    .clock(clock),
    .reset(reset),
    .restart(phaseRestart),
    .limit(phaseLimit),
    .phaseStart(phaseStart),
    .firstHalf(firstHalf)
  );

  // switching pulses and the driven pin; follow mode never drives
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      switchPulse <= 1'b0;
      clockPinOut <= 1'b0;
      clockPinOe <= 1'b0;
    end else begin
      switchPulse <= phaseStart && switchEnable;
      clockPinOe <= (state == clock_monitor_pkg::DRIVE_RUN);
      clockPinOut <= (state == clock_monitor_pkg::DRIVE_RUN) &&
        firstHalf;
    end
  end

  // live flag, follows the state with no latching
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lossFlag <= 1'b0;
    end else begin
      lossFlag <= (state == clock_monitor_pkg::FOLLOW_WAIT ||
        state == clock_monitor_pkg::FOLLOW_RESTORE) &&
        !faultDisable;
    end
  end

  // clock loss is reported only by status, alert stays quiet
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busAlert <= 1'b0;
    end else begin
      busAlert <= 1'b0;
    end
  end

  // configuration register, cleared at power-up
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      misc <= clock_monitor_pkg::MISC_RESET;
    end else if (regWrite && regAddr == clock_monitor_pkg::MISC_OFFSET) begin
      misc <= {5'h00, regWriteData[2:0]};
    end
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (regAddr == clock_monitor_pkg::MISC_OFFSET) begin
      regReadData <= misc;
    end else if (regAddr == clock_monitor_pkg::STATUS_OFFSET) begin
      regReadData <= {switchEnable, followMode, lossFlag, 5'h00};
    end else begin
      regReadData <= 8'h00;
    end
  end

  sequence s_seventh_edge;
    state == clock_monitor_pkg::FOLLOW_RESTORE &&
      restoreCount == RESTORE_LAST && validEdge && !lossSeen;
  endsequence

  sequence s_soft_start;
    state == clock_monitor_pkg::FOLLOW_RUN && softStartPulse;
  endsequence

  property p_restart;
    @(posedge clock) disable iff (reset)
    s_seventh_edge |=> s_soft_start;
  endproperty
  a_restart: assert property (p_restart)
    else $error("no soft-start after seventh returned edge");

  property p_drive_pin;
    @(posedge clock) disable iff (reset)
    state == clock_monitor_pkg::DRIVE_RUN |=> clockPinOe && !followMode;
  endproperty
  a_drive_pin: assert property (p_drive_pin)
    else $error("drive mode without pin enable");

  property p_follow_quiet;
    @(posedge clock) disable iff (reset)
    followMode |-> !clockPinOe;
  endproperty
  a_follow_quiet: assert property (p_follow_quiet)
    else $error("pin driven in follow mode");

  property p_slave_follows;
    @(posedge clock) disable iff (reset)
    state != clock_monitor_pkg::DETECT && slaveRole |-> followMode;
  endproperty
  a_slave_follows: assert property (p_slave_follows)
    else $error("loop slave not in follow mode");

  property p_mode_held;
    @(posedge clock) disable iff (reset)
    state != clock_monitor_pkg::DETECT |=> $stable(followMode) &&
      state != clock_monitor_pkg::DETECT;
  endproperty
  a_mode_held: assert property (p_mode_held)
    else $error("pin mode changed after decision");

  property p_force_follow;
    @(posedge clock) disable iff (reset)
    detectDone && misc[clock_monitor_pkg::FORCE_FOLLOW_BIT] |=> followMode;
  endproperty
  a_force_follow: assert property (p_force_follow)
    else $error("force-follow did not win");

  property p_loss_latency;
    @(posedge clock) disable iff (reset)
    state == clock_monitor_pkg::FOLLOW_RUN && !lockEdge &&
      gap == 8'(LOSS_CYC - 1) |=> ##1 state != clock_monitor_pkg::FOLLOW_RUN;
  endproperty
  a_loss_latency: assert property (p_loss_latency)
    else $error("clock loss not detected in time");

  property p_wait_off;
    @(posedge clock) disable iff (reset)
    state == clock_monitor_pkg::FOLLOW_WAIT && !faultDisable
      |=> !switchPulse && lossFlag;
  endproperty
  a_wait_off: assert property (p_wait_off)
    else $error("switching or no flag while clock missing");

  property p_no_alert;
    @(posedge clock) disable iff (reset)
    $rose(lossFlag) |-> !busAlert;
  endproperty
  a_no_alert: assert property (p_no_alert)
    else $error("alert raised by clock loss");

  property p_disable_quiet;
    @(posedge clock) disable iff (reset)
    faultDisable && $past(faultDisable) |=> !lossFlag;
  endproperty
  a_disable_quiet: assert property (p_disable_quiet)
    else $error("loss flag shown while reporting disabled");
endmodule

// ---- verification/external_clock_source.sv ----
// behavioural model of an external clock source on the shared clock pin
`timescale 1ns/1ps
module external_clock_source (
  input wire logic run,
  input wire logic [31:0] halfNs,
  output logic pinLevel
);
  // equal high and low halves keep a stack interleaved
  // stops low at the end of a whole period when run drops, so it never
  // fights a pin in drive mode once the bench has stopped it
  initial begin
    pinLevel = 1'b0;
    forever begin
      // restart a few ns off the bench clock edge, so the pin never
      // moves in the time step of a sampling edge
      if (!run) begin
        wait (run);
        #3;
      end
      #(halfNs) pinLevel = 1'b1;
      #(halfNs) pinLevel = 1'b0;
    end
  end
endmodule

// ---- verification/switching_clock_lock_and_loss_monitor_bench.sv ----
// testbench for the clock lock and loss monitor
`timescale 1ns/1ps
module switching_clock_lock_and_loss_monitor_bench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic loopSlaveStrap = 1'b0;
  logic [6:0] periodStrap = 7'h28;
  logic [7:0] regAddr = 8'h00;
  logic regWrite = 1'b0;
  logic [7:0] regWriteData = 8'h00;
  logic [7:0] regReadData;
  logic clockPinOut, clockPinOe, switchPulse, softStartPulse;
  logic followMode, busAlert, srcLevel, pinLevel;
  logic srcRun = 1'b0;
  int srcHalf = 1000;
  int n_mismatch = 0;
  int n_tests = 0;
  int nSwitch, nSoft, nHigh, nPinHigh;
  logic [7:0] rd;

  // the pin carries the device only while it drives it
  assign pinLevel = clockPinOe ? clockPinOut : srcLevel;

  switching_clock_monitor i_switching_clock_monitor (
    .clock(clock), .reset(reset), .clockPinIn(pinLevel),
    .loopSlaveStrap(loopSlaveStrap), .periodStrap(periodStrap),
    .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
    .regReadData(regReadData), .clockPinOut(clockPinOut),
    .clockPinOe(clockPinOe), .switchPulse(switchPulse),
    .softStartPulse(softStartPulse), .followMode(followMode),
    .busAlert(busAlert)
  );

  external_clock_source i_external_clock_source (
    .run(srcRun), .halfNs(srcHalf), .pinLevel(srcLevel)
  );

  initial begin
    forever #25 clock = ~clock;
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    regAddr <= addr;
    regWrite <= 1'b1;
    regWriteData <= data;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  // read data is registered one cycle after the address
  task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clock);
    regAddr <= addr;
    repeat (2) @(posedge clock);
    #1 data = regReadData;
  endtask

  // count pulses and driven high cycles over a span
  task automatic watch(input int cycles);
    nSwitch = 0;
    nSoft = 0;
    nHigh = 0;
    nPinHigh = 0;
    repeat (cycles) begin
      @(posedge clock);
      #1;
      nSwitch += int'(switchPulse);
      // pin level at each switching start shows which edge was locked
      nPinHigh += int'(switchPulse && pinLevel);
      nSoft += int'(softStartPulse);
      nHigh += int'(clockPinOut);
      if (busAlert !== 1'b0) begin
        check(8'(busAlert), 8'h00);
      end
    end
  endtask

  // power up with straps, source and stored bits set before the decision
  task automatic startUp(input logic slave, input logic [7:0] misc,
                         input logic run, input int half);
    @(posedge clock);
    reset <= 1'b1;
    loopSlaveStrap <= slave;
    srcRun <= run;
    srcHalf <= half;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    // a zero byte is left at its power-up value, so that value is seen
    if (misc != 8'h00) begin
      writeReg(clock_monitor_pkg::MISC_OFFSET, misc);
    end
    repeat (210) @(posedge clock);
    #1;
  endtask

  // hang guard, well above the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    // no clock at power-up: drive mode, own clock out
    startUp(1'b0, 8'h00, 1'b0, 1000);
    check({followMode, clockPinOe}, 8'h01);
    watch(400);
    check(8'(nSwitch), 8'h0A);
    check(8'(nHigh), 8'hC8);
    readReg(8'h80, rd);
    check(rd, 8'h80);
    writeReg(8'h12, 8'hFF);
    readReg(8'h12, rd);
    check(rd, 8'h00);
    writeReg(clock_monitor_pkg::MISC_OFFSET, 8'hFF);
    readReg(clock_monitor_pkg::MISC_OFFSET, rd);
    check(rd, 8'h07);
    watch(100);
    check({followMode, clockPinOe}, 8'h01);

    // clock present at power-up: follow, lock, lose and regain it
    startUp(1'b0, 8'h00, 1'b1, 1000);
    readReg(clock_monitor_pkg::MISC_OFFSET, rd);
    check(rd, clock_monitor_pkg::MISC_RESET);
    check({followMode, clockPinOe}, 8'h02);
    watch(600);
    check(8'(nSoft), 8'h01);
    watch(400);
    check(8'(nSwitch), 8'h0A);
    check(8'(nPinHigh), 8'h0A);
    readReg(8'h80, rd);
    check(rd, 8'hC0);
    srcRun <= 1'b0;
    watch(260);
    readReg(8'h80, rd);
    check(rd, 8'h60);
    watch(200);
    check(8'(nSwitch), 8'h00);
    srcRun <= 1'b1;
    watch(500);
    check(8'(nSoft), 8'h01);

    // clock outside the lock window never starts switching
    startUp(1'b0, 8'h00, 1'b1, 1500);
    check(8'(followMode), 8'h01);
    watch(600);
    check(8'(nSoft + nSwitch), 8'h00);

    // both force bits, no clock: follow wins and stays off
    startUp(1'b0, 8'h06, 1'b0, 1000);
    check({followMode, clockPinOe}, 8'h02);
    watch(400);
    check(8'(nSwitch), 8'h00);
    readReg(8'h80, rd);
    check(rd, 8'h60);

    // loop slave with fault disable: no flag, keeps switching at free run
    startUp(1'b1, 8'h01, 1'b1, 1000);
    check({followMode, clockPinOe}, 8'h02);
    watch(600);
    check(8'(nSoft), 8'h00);
    watch(400);
    check(8'(nSwitch), 8'h0A);
    check(8'(nPinHigh), 8'h00);
    srcRun <= 1'b0;
    watch(300);
    readReg(8'h80, rd);
    check(rd & 8'h20, 8'h00);
    watch(400);
    check(8'(nSwitch), 8'h0A);

    // strap beyond the slowest period is clamped to it
    @(posedge clock) periodStrap <= 7'h7F;
    startUp(1'b0, 8'h00, 1'b0, 1000);
    watch(400);
    check(8'(nSwitch), 8'h04);
    check(8'(nHigh), 8'hC8);
    report_and_stop();
  end
endmodule
